// >>> hdl/cbsm_bank.sv

`include "cbsm_consts.svh"

module cbsm_bank #(
	parameter logic [1:0] IMP_RESET = `CBSM_IMP_100,
	parameter logic [3:0] REVISION = 4'h3, // arbitrary value
	parameter logic [3:0] VENDOR = 4'ha, // arbitrary value
	parameter logic [1:0] CATEGORY = 2'h2, // arbitrary value
	parameter logic [5:0] DEVICE_ID = 6'h15 // arbitrary value
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// smbus pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// strap and power
	input wire logic [1:0] address_strap,
	input wire logic pd_b,
	// output enables from outside this bank
	input wire logic [`CBSM_N_OUT-1:0] output_enable_bits,
	input wire logic [`CBSM_N_OUT-1:0] oe_pin_b,
	// output stage drive
	output logic [`CBSM_N_OUT-1:0] clock_output_run,
	output logic [`CBSM_N_OUT-1:0] clock_output_true,
	output logic [`CBSM_N_OUT-1:0] clock_output_comp,
	output logic [`CBSM_N_OUT-1:0] clock_output_high_impedance,
	// configuration
	output logic [`CBSM_N_OUT-1:0] edge_rate_select,
	output logic [1:0] output8_impedance_sel,
	output logic [1:0] disabled_output_state,
	output logic powerdown_config_keep,
	output logic [4:0] readback_count,
	output logic [6:0] target_address
);

	cbsm_pkg::cbsm_state_type state;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sda_q;
	logic [3:0] bit_cnt;
	logic [7:0] shifter;
	logic rw_read;
	logic ack_n;
	logic [1:0] byte_phase;
	logic [7:0] reg_idx;
	logic [7:0] wr_left;
	logic rd_first;
	logic strap_taken;
	logic byte_done;
	logic wr_en;
	logic tx_load;
	logic restore;
	logic [7:0] tx_byte;

	cbsm_edge u_edge (
		.clk(clk),
		.rst_b(rst_b),
		.scl(scl),
		.sda(sda_in),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det),
		.sda_q(sda_q)
	);

	cbsm_outctl #(
		.N(`CBSM_N_OUT)
	) u_outctl (
		.clk(clk),
		.rst_b(rst_b),
		.pd_b(pd_b),
		.enable_bits(output_enable_bits),
		.oe_pin_b(oe_pin_b),
		.disabled_output_state(disabled_output_state),
		.run(clock_output_run),
		.level_true(clock_output_true),
		.level_comp(clock_output_comp),
		.high_impedance(clock_output_high_impedance)
	);

	function automatic logic wr_hit(input logic en, input logic [7:0] idx,
		input logic [7:0] target);
		return en && (idx == target);
	endfunction

	// register read map; unknown indices read zero
	function automatic logic [7:0] read_reg(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`CBSM_IDX_SLEW_LO: v = edge_rate_select[7:0];
			`CBSM_IDX_SLEW_HI: v = {7'h00, edge_rate_select[8]};
			`CBSM_IDX_RSVD_ONES: v = `CBSM_RSVD_ONES;
			`CBSM_IDX_REV_VEN: v = {REVISION, VENDOR};
			`CBSM_IDX_CAT_DEV: v = {CATEGORY, DEVICE_ID};
			`CBSM_IDX_COUNT: v = {3'h0, readback_count};
			`CBSM_IDX_RSVD_8: v = 8'h00;
			`CBSM_IDX_RSVD_9: v = 8'h00;
			`CBSM_IDX_PD_KEEP: v = {1'b0, powerdown_config_keep, 6'h00};
			`CBSM_IDX_IMP_DIS: v = {output8_impedance_sel, 4'h0, disabled_output_state};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	assign byte_done = scl_fall && (bit_cnt == 4'h8);
	assign wr_en = (state == cbsm_pkg::CBSM_ST_RX) && byte_done
		&& (byte_phase == 2'h2) && (wr_left != 8'h00);
	assign tx_load = scl_fall && rw_read
		&& ((state == cbsm_pkg::CBSM_ST_ADDR_ACK)
		|| (state == cbsm_pkg::CBSM_ST_TX_ACK && !ack_n));
	assign restore = !pd_b && !powerdown_config_keep;

	// count byte goes first in a block read; always_comb also follows the stored fields
	always_comb begin
		tx_byte = rd_first ? {3'h0, readback_count} : read_reg(reg_idx);
	end

	// open-drain: only ever pull low
	always_ff @(posedge clk) begin
		sda_out <= 1'b0;
	end

	// address strap caught once power is good
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			strap_taken <= 1'b0;
			target_address <= `CBSM_ADDR_LOW;
		end else if (pd_b && !strap_taken) begin
			strap_taken <= 1'b1;
			unique case (cbsm_pkg::cbsm_strap_type'(address_strap))
				cbsm_pkg::CBSM_STRAP_LOW: target_address <= `CBSM_ADDR_LOW;
				cbsm_pkg::CBSM_STRAP_MID: target_address <= `CBSM_ADDR_MID;
				cbsm_pkg::CBSM_STRAP_HIGH: target_address <= `CBSM_ADDR_HIGH;
				default: target_address <= `CBSM_ADDR_LOW;
			endcase
		end
	end

	// bit-level target state machine
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state <= cbsm_pkg::CBSM_ST_IDLE;
			bit_cnt <= 4'h0;
			shifter <= 8'h00;
			rw_read <= 1'b0;
			ack_n <= 1'b1;
			sda_oe <= 1'b0;
		end else if (start_det) begin
			state <= cbsm_pkg::CBSM_ST_ADDR;
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_det) begin
			state <= cbsm_pkg::CBSM_ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				cbsm_pkg::CBSM_ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				cbsm_pkg::CBSM_ST_ADDR, cbsm_pkg::CBSM_ST_RX: begin
					if (scl_rise) begin
						shifter <= {shifter[6:0], sda_q};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						bit_cnt <= 4'h0;
						if (state == cbsm_pkg::CBSM_ST_ADDR) begin
							rw_read <= shifter[0];
							if (shifter[7:1] == target_address) begin
								sda_oe <= 1'b1;
								state <= cbsm_pkg::CBSM_ST_ADDR_ACK;
							end else begin
								state <= cbsm_pkg::CBSM_ST_IDLE;
							end
						end else begin
							// every received byte is acknowledged
							sda_oe <= 1'b1;
							state <= cbsm_pkg::CBSM_ST_RX_ACK;
						end
					end
				end
				cbsm_pkg::CBSM_ST_ADDR_ACK, cbsm_pkg::CBSM_ST_RX_ACK: begin
					if (tx_load) begin
						sda_oe <= !tx_byte[7];
						shifter <= {tx_byte[6:0], 1'b0};
						bit_cnt <= 4'h1;
						state <= cbsm_pkg::CBSM_ST_TX;
					end else if (scl_fall) begin
						sda_oe <= 1'b0;
						state <= cbsm_pkg::CBSM_ST_RX;
					end
				end
				cbsm_pkg::CBSM_ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_oe <= 1'b0;
							bit_cnt <= 4'h0;
							state <= cbsm_pkg::CBSM_ST_TX_ACK;
						end else begin
							sda_oe <= !shifter[7];
							shifter <= {shifter[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				cbsm_pkg::CBSM_ST_TX_ACK: begin
					if (scl_rise) begin
						ack_n <= sda_q;
					end else if (tx_load) begin
						sda_oe <= !tx_byte[7];
						shifter <= {tx_byte[6:0], 1'b0};
						bit_cnt <= 4'h1;
						state <= cbsm_pkg::CBSM_ST_TX;
					end else if (scl_fall) begin
						// host not-acknowledge ends the read
						state <= cbsm_pkg::CBSM_ST_IDLE;
					end
				end
			endcase
		end
	end

	// index, count and write bookkeeping
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			byte_phase <= 2'h0;
			reg_idx <= 8'h00;
			wr_left <= 8'h00;
			rd_first <= 1'b1;
		end else if (start_det) begin
			byte_phase <= 2'h0;
			rd_first <= 1'b1;
		end else if (byte_done && state == cbsm_pkg::CBSM_ST_RX) begin
			unique case (byte_phase)
				2'h0: begin
					reg_idx <= shifter;
					byte_phase <= 2'h1;
				end
				2'h1: begin
					wr_left <= shifter;
					byte_phase <= 2'h2;
				end
				default: begin
					if (wr_left != 8'h00) begin
						reg_idx <= reg_idx + 8'h01;
						wr_left <= wr_left - 8'h01;
					end
				end
			endcase
		end else if (tx_load) begin
			if (rd_first) begin
				rd_first <= 1'b0;
			end else begin
				reg_idx <= reg_idx + 8'h01;
			end
		end
	end

	// configuration store; read-only and reserved bits are never stored
	always_ff @(posedge clk) begin
		if (!rst_b || restore) begin
			edge_rate_select <= `CBSM_SLEW_RESET;
			readback_count <= `CBSM_COUNT_RESET;
			output8_impedance_sel <= IMP_RESET;
			disabled_output_state <= `CBSM_DIS_RESET;
		end else begin
			if (wr_hit(wr_en, reg_idx, `CBSM_IDX_SLEW_LO))
				edge_rate_select[7:0] <= shifter;
			if (wr_hit(wr_en, reg_idx, `CBSM_IDX_SLEW_HI))
				edge_rate_select[8] <= shifter[`CBSM_SLEW8_BIT];
			if (wr_hit(wr_en, reg_idx, `CBSM_IDX_COUNT))
				readback_count <= shifter[`CBSM_COUNT_MSB:0];
			if (wr_hit(wr_en, reg_idx, `CBSM_IDX_IMP_DIS)) begin
				output8_impedance_sel <= shifter[`CBSM_IMP_MSB:`CBSM_IMP_LSB];
				disabled_output_state <= shifter[`CBSM_DIS_MSB:`CBSM_DIS_LSB];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			powerdown_config_keep <= `CBSM_KEEP_RESET;
		end else if (wr_hit(wr_en, reg_idx, `CBSM_IDX_PD_KEEP)) begin
			powerdown_config_keep <= shifter[`CBSM_KEEP_BIT];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence addr_match_s;
		state == cbsm_pkg::CBSM_ST_ADDR && byte_done && shifter[7:1] == target_address;
	endsequence

	sequence nack_end_s;
		state == cbsm_pkg::CBSM_ST_TX_ACK && ack_n && scl_fall && !start_det && !stop_det;
	endsequence

	reset_values_a:
	assert property (!$past(rst_b) |-> edge_rate_select == 9'h1ff
		&& readback_count == 5'h08 && powerdown_config_keep
		&& output8_impedance_sel == IMP_RESET && disabled_output_state == 2'h0)
	else $error("configuration not at reset values");

	slew_write_a:
	assert property (pd_b && wr_en && reg_idx == 8'h02 |=> edge_rate_select[7:0] == $past(shifter))
	else $error("edge rate byte not stored");

	reserved_ones_a:
	assert property (tx_load && !rd_first && reg_idx == 8'h04 |=> !sda_oe && shifter == 8'hfe)
	else $error("reserved byte did not read all ones");

	ident_read_a:
	assert property (tx_load && !rd_first && reg_idx == 8'h05
		|=> sda_oe == !REVISION[3] && shifter == {REVISION[2:0], VENDOR, 1'b0})
	else $error("revision and vendor byte wrong");

	count_write_a:
	assert property (pd_b && wr_en && reg_idx == 8'h07
		|=> readback_count == $past(shifter[4:0]) ##1 $stable(readback_count) || wr_en)
	else $error("count field not stored from low bits");

	count_first_a:
	assert property (tx_load && rd_first |=> sda_oe && shifter[7:6] == 2'h0 && !rd_first)
	else $error("count byte not sent first");

	addr_ack_a:
	assert property (addr_match_s |=> sda_oe && state == cbsm_pkg::CBSM_ST_ADDR_ACK)
	else $error("own address not acknowledged");

	nack_idle_a:
	assert property (nack_end_s |=> state == cbsm_pkg::CBSM_ST_IDLE ##1 !sda_oe)
	else $error("read not ended by host not-acknowledge");

	pd_restore_a:
	assert property (!pd_b && !powerdown_config_keep
		|=> edge_rate_select == 9'h1ff && readback_count == 5'h08)
	else $error("configuration not restored in power-down");

	imp_write_a:
	assert property (pd_b && wr_en && reg_idx == 8'h0b |=> output8_impedance_sel ==
		$past(shifter[7:6]) && disabled_output_state == $past(shifter[1:0]))
	else $error("impedance or disable code not stored");

endmodule

// >>> hdl/cbsm_consts.svh
`ifndef CBSM_CONSTS_SVH
`define CBSM_CONSTS_SVH

// register byte indices
`define CBSM_IDX_SLEW_LO 8'h02
`define CBSM_IDX_SLEW_HI 8'h03
`define CBSM_IDX_RSVD_ONES 8'h04
`define CBSM_IDX_REV_VEN 8'h05
`define CBSM_IDX_CAT_DEV 8'h06
`define CBSM_IDX_COUNT 8'h07
`define CBSM_IDX_RSVD_8 8'h08
`define CBSM_IDX_RSVD_9 8'h09
`define CBSM_IDX_PD_KEEP 8'h0a
`define CBSM_IDX_IMP_DIS 8'h0b

// field positions
`define CBSM_SLEW8_BIT 0
`define CBSM_KEEP_BIT 6
`define CBSM_IMP_MSB 7
`define CBSM_IMP_LSB 6
`define CBSM_DIS_MSB 1
`define CBSM_DIS_LSB 0
`define CBSM_COUNT_MSB 4

// reset values
`define CBSM_SLEW_RESET 9'h1ff
`define CBSM_COUNT_RESET 5'h08
`define CBSM_KEEP_RESET 1'b1
`define CBSM_DIS_RESET 2'h0
`define CBSM_RSVD_ONES 8'hff

// impedance codes
`define CBSM_IMP_33 2'h0
`define CBSM_IMP_85 2'h1
`define CBSM_IMP_100 2'h2

// target addresses per strap level
`define CBSM_ADDR_LOW 7'h6b
`define CBSM_ADDR_MID 7'h6c
`define CBSM_ADDR_HIGH 7'h6d

`define CBSM_N_OUT 9

`endif

// >>> hdl/cbsm_edge.sv
module cbsm_edge (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bus pins
	input wire logic scl,
	input wire logic sda,
	// events
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det,
	output logic sda_q
);

	logic scl_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// data moving while the clock is high marks start or stop
	assign scl_rise = scl && !scl_q;
	assign scl_fall = !scl && scl_q;
	assign start_det = scl && scl_q && sda_q && !sda;
	assign stop_det = scl && scl_q && !sda_q && sda;

endmodule

// >>> hdl/cbsm_outctl.sv
`include "cbsm_consts.svh"

module cbsm_outctl #(
	parameter int N = `CBSM_N_OUT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// controls
	input wire logic pd_b,
	input wire logic [N-1:0] enable_bits,
	input wire logic [N-1:0] oe_pin_b,
	input wire logic [1:0] disabled_output_state,
	// output stage drive
	output logic [N-1:0] run,
	output logic [N-1:0] level_true,
	output logic [N-1:0] level_comp,
	output logic [N-1:0] high_impedance
);

	cbsm_pkg::cbsm_dis_type dis;
	assign dis = cbsm_pkg::cbsm_dis_type'(disabled_output_state);

	for (genvar i = 0; i < N; i++) begin : g_out
		always_ff @(posedge clk) begin
			if (!rst_b || !pd_b) begin
				run[i] <= 1'b0;
				level_true[i] <= 1'b0;
				level_comp[i] <= 1'b0;
				high_impedance[i] <= 1'b0;
			end else if (enable_bits[i] && !oe_pin_b[i]) begin
				run[i] <= 1'b1;
				level_true[i] <= 1'b0;
				level_comp[i] <= 1'b0;
				high_impedance[i] <= 1'b0;
			end else begin
				// a cleared enable bit overrides the pin
				run[i] <= 1'b0;
				level_true[i] <= (dis == cbsm_pkg::CBSM_DIS_HIGH_LOW);
				level_comp[i] <= (dis == cbsm_pkg::CBSM_DIS_LOW_HIGH);
				high_impedance[i] <= (dis == cbsm_pkg::CBSM_DIS_HIGH_IMPEDANCE);
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	disable_override_a:
	assert property (pd_b && !enable_bits[0] |=> !run[0]
		&& high_impedance[0] == ($past(disabled_output_state) == 2'h1)
		&& level_true[0] == ($past(disabled_output_state) == 2'h2))
	else $error("disabled output not in selected state");

endmodule

// >>> hdl/cbsm_pkg.sv
package cbsm_pkg;

	typedef enum logic [2:0] {
		CBSM_ST_IDLE,
		CBSM_ST_ADDR,
		CBSM_ST_ADDR_ACK,
		CBSM_ST_RX,
		CBSM_ST_RX_ACK,
		CBSM_ST_TX,
		CBSM_ST_TX_ACK
	} cbsm_state_type;

	typedef enum logic [1:0] {
		CBSM_DIS_LOW_LOW,
		CBSM_DIS_HIGH_IMPEDANCE,
		CBSM_DIS_HIGH_LOW,
		CBSM_DIS_LOW_HIGH
	} cbsm_dis_type;

	typedef enum logic [1:0] {
		CBSM_STRAP_LOW,
		CBSM_STRAP_MID,
		CBSM_STRAP_HIGH
	} cbsm_strap_type;

endpackage

// >>> tb/cbsm_host.sv
module cbsm_host (
	// clock
	input wire logic clk,
	// level seen on the pulled-up data wire
	input wire logic sda,
	// host drive, released data reads as one through the pull-up
	output logic scl,
	output logic sda_drv
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	// each clock phase lasts four cycles, above the two the target needs
	task automatic put_bit(input logic b);
		sda_drv = b;
		gap(4);
		scl = 1'b1;
		gap(4);
		scl = 1'b0;
	endtask

	task automatic get_bit(output logic b);
		sda_drv = 1'b1;
		gap(4);
		scl = 1'b1;
		gap(2);
		b = sda;
		gap(2);
		scl = 1'b0;
	endtask

	task automatic start_cond();
		sda_drv = 1'b1;
		gap(4);
		scl = 1'b1;
		gap(4);
		sda_drv = 1'b0;
		gap(4);
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		sda_drv = 1'b0;
		gap(4);
		scl = 1'b1;
		gap(4);
		sda_drv = 1'b1;
		gap(4);
	endtask

	// msb first, then the acknowledge slot; any missing ack sets nak
	task automatic put_byte(input logic [7:0] d, inout logic nak);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(a);
		nak = nak | a;
	endtask

	task automatic get_byte(output logic [7:0] d, input logic last);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			get_bit(b);
			d[i] = b;
		end
		put_bit(last);
	endtask

	task automatic write_block(input logic [6:0] adr, input logic [7:0] idx,
		input logic [7:0] n, input logic [7:0] d [0:11], output logic nak);
		nak = 1'b0;
		start_cond();
		put_byte({adr, 1'b0}, nak);
		put_byte(idx, nak);
		put_byte(n, nak);
		for (int i = 0; i < n; i++) begin
			put_byte(d[i], nak);
		end
		stop_cond();
	endtask

	// q[0] takes the count byte, then n data bytes; the last one is not acknowledged
	task automatic read_block(input logic [6:0] adr, input logic [7:0] idx,
		input int n, output logic [7:0] q [0:11], output logic nak);
		logic [7:0] v;
		nak = 1'b0;
		start_cond();
		put_byte({adr, 1'b0}, nak);
		put_byte(idx, nak);
		start_cond();
		put_byte({adr, 1'b1}, nak);
		for (int i = 0; i <= n; i++) begin
			get_byte(v, i == n);
			q[i] = v;
		end
		stop_cond();
	endtask
endmodule

// >>> tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [3:0] REV = 4'h6; // arbitrary value
	localparam logic [3:0] VEN = 4'h5; // arbitrary value
	localparam logic [1:0] CAT = 2'h1; // arbitrary value
	localparam logic [5:0] DEV = 6'h2c; // arbitrary value

	logic clk, rst_b, pd_b, scl, sda_drv, sda, sda_out, sda_oe, keep, nak;
	logic [1:0] address_strap, imp, dis, cv, lv;
	logic [8:0] output_enable_bits, oe_pin_b, run, tru, comp, high_impedance, edge_rate_select;
	logic [4:0] readback_count;
	logic [6:0] target_address;
	logic [7:0] wd [0:11];
	logic [7:0] rd [0:11];
	logic [7:0] exp_rd [0:11];
	logic [6:0] adr_tab [0:2];
	int n_fail, total_checks;

	// open-drain wire with pull-up
	assign sda = sda_drv & ~(sda_oe & ~sda_out);

	cbsm_bank #(.REVISION(REV), .VENDOR(VEN), .CATEGORY(CAT), .DEVICE_ID(DEV)) i_cbsm_bank (
		.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .address_strap(address_strap), .pd_b(pd_b),
		.output_enable_bits(output_enable_bits), .oe_pin_b(oe_pin_b),
		.clock_output_run(run), .clock_output_true(tru), .clock_output_comp(comp),
		.clock_output_high_impedance(high_impedance), .edge_rate_select(edge_rate_select),
		.output8_impedance_sel(imp), .disabled_output_state(dis),
		.powerdown_config_keep(keep), .readback_count(readback_count),
		.target_address(target_address)
	);

	cbsm_host i_cbsm_host (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		if (n_fail == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic gap(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic do_reset(input logic [1:0] strap);
		@(negedge clk);
		rst_b = 1'b0;
		address_strap = strap;
		gap(16);
		rst_b = 1'b1;
		gap(4);
	endtask

	task automatic read_cmp(input int n);
		i_cbsm_host.read_block(7'h6b, 8'h02, n, rd, nak);
		check("read ack", nak, 1'b0);
		for (int i = 0; i <= n; i++) begin
			if (i < 3) begin
				check($sformatf("read %0d", i), rd[i], exp_rd[i]);
			end else if (i < 6) begin
				check($sformatf("read %0d", i), rd[i], exp_rd[i]);
			end else begin
				check($sformatf("read %0d", i), rd[i], exp_rd[i]);
			end
		end
	endtask

	initial begin
		gap(100000);
		n_fail++;
		summarize();
	end

	initial begin
		rst_b = 1'b0;
		pd_b = 1'b1;
		address_strap = 2'h0;
		output_enable_bits = 9'h1ff;
		oe_pin_b = 9'h000;
		n_fail = 0;
		total_checks = 0;
		adr_tab = '{7'h6b, 7'h6c, 7'h6d};
		wd = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		// strap loop ends on the low address used by the rest of the run
		for (int s = 1; s <= 3; s++) begin
			do_reset(2'(s % 3));
			check("target_address", target_address, adr_tab[s % 3]);
		end
		i_cbsm_host.write_block(7'h6c, 8'h02, 8'h01, wd, nak);
		check("foreign address nack", nak, 1'b1);
		// defaults, continuing past the count up to an unmapped index
		exp_rd = '{8'h08, 8'hff, 8'h01, 8'hff, {REV, VEN}, {CAT, DEV}, 8'h08, 8'h00, 8'h00,
			8'h40, 8'h80, 8'h00};
		read_cmp(11);
		// writes hit writable, read-only and reserved bits alike
		wd = '{8'h5a, 8'hfe, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc3, 8'h00, 8'h00};
		i_cbsm_host.write_block(7'h6b, 8'h02, 8'd10, wd, nak);
		check("write ack", nak, 1'b0);
		check("edge_rate_select", edge_rate_select, 9'h05a);
		check("readback_count", readback_count, 5'h1f);
		check("impedance", imp, 2'h3);
		check("disabled state", dis, 2'h3);
		check("keep", keep, 1'b1);
		exp_rd = '{8'h1f, 8'h5a, 8'h00, 8'hff, {REV, VEN}, {CAT, DEV}, 8'h1f, 8'h00, 8'h00,
			8'h40, 8'hc3, 8'h00};
		read_cmp(10);
		// every disabled-state and impedance code on bit-disabled output 0; pin-disabled output 2 for the level codes only
		for (int c = 0; c < 4; c++) begin
			cv = 2'(c);
			// expected {true, complement} levels of a disabled output
			lv = (cv == 2'h2) ? 2'h2 : (cv == 2'h3) ? 2'h1 : 2'h0;
			wd[0] = {cv, 4'h0, cv};
			i_cbsm_host.write_block(7'h6b, 8'h0b, 8'h01, wd, nak);
			output_enable_bits = 9'h1fe;
			oe_pin_b = 9'h004;
			gap(3);
			check("impedance code", imp, cv);
			check("run", run[2:0], 3'h2);
			check("high impedance", high_impedance[0], cv == 2'h1);
			if (cv != 2'h1) begin
				check("levels", {tru[0], comp[0]}, lv);
				check("pin levels", {tru[2], comp[2]}, lv);
			end
			output_enable_bits = 9'h1ff;
			oe_pin_b = 9'h000;
		end
		// power-down keeps configuration, then restores once keep is cleared
		pd_b = 1'b0;
		gap(3);
		check("pd run", run, 9'h000);
		check("pd levels", {tru, comp}, 18'h0);
		check("pd kept slew", edge_rate_select, 9'h05a);
		wd[0] = 8'h00;
		i_cbsm_host.write_block(7'h6b, 8'h0a, 8'h01, wd, nak);
		gap(3);
		check("keep cleared", keep, 1'b0);
		check("restored slew", edge_rate_select, 9'h1ff);
		check("restored count", readback_count, 5'h08);
		check("restored state", dis, 2'h0);
		check("restored impedance", imp, 2'h2);
		pd_b = 1'b1;
		gap(4);
		summarize();
	end
endmodule
